/* rtl/efc_pkg.sv */
// What this block does
// - harmonic-ready selected on pin two: converter two output is kept off that pin
// - capture port enabled: pin three carries its clock, not converter three output
// - three independent converters, each summing selected phase powers into a pulse rate
// - phase-inclusion fields sit at computation mode bits 2:0, 5:3, 8:6
// - field bit 0 phase A, bit 1 phase B, bit 2 phase C; one includes
// - all inclusion bits zero: no power summed, no pulses at all
// - power-type fields sit at pulse config bits 2:0, 5:3, 8:6
// - codes 000 total active, 010 apparent, 011 fund active, 100 fund reactive
// - reset: inclusion bits all one, types 000, 100, 010 for converters one to three
// - second stage divides first-stage pulses by a 16-bit unsigned divisor
// - divisor one gives 1 us low pulse; divisor zero behaves as one
// - period above 160 ms: each low phase lasts exactly 80 ms
// - shorter period with even divisor: exactly 50 percent duty
// - shorter period with odd divisor: low lasts (1 + 1/divisor) times half the period, but never more than 80 ms
// - disable bits 11:9 for pins three..one; one holds pin high, reset one
// - mask bits 16:14; falling converter edge sets status bit and drives interrupt
// - status and interrupt still work while the pin output is disabled
// - latch copies all three phase energies of selected type, then clears them
// - 8-bit cycle count sets falling edges between two latch events
// - latch enable bits 14:12 for converters three..one, reset zero, work when disabled
// - latched energy set follows the converter power type code
// - writing one to a status bit clears it and releases the interrupt line
// - first stage pulses each time accumulated energy reaches the threshold
package efc_pkg;
  localparam int NCONV = 3;
  localparam int NTYPE = 4;
  localparam int NHOUR = 12;
  localparam logic [4:0] ADDR_COMPUTATION_MODE_REG = 5'h00;
  localparam logic [4:0] ADDR_PULSE_CONFIG_REG = 5'h01;
  localparam logic [4:0] ADDR_DEN0 = 5'h02;
  localparam logic [4:0] ADDR_LATCH_CYCLE_COUNT = 5'h05;
  localparam logic [4:0] ADDR_MASK = 5'h06;
  localparam logic [4:0] ADDR_STATUS = 5'h07;
  localparam logic [4:0] ADDR_HOUR0 = 5'h08;
  localparam int TERM_W = 3;
  localparam int SEL_W = 3;
  localparam int DIS_LSB = 9;
  localparam int LATCH_LSB = 12;
  localparam int IRQ_LSB = 14;
  localparam logic [8:0] COMPUTATION_MODE_REG_RST = 9'h1ff;
  localparam logic [14:0] PULSE_CONFIG_REG_RST = 15'h0ea0;
  localparam logic [15:0] DEN_RST = 16'h0000;
  localparam logic [7:0] LATCH_CYCLE_COUNT_RST = 8'h01;
  localparam logic [2:0] SEL_TOTAL = 3'h0;
  localparam logic [2:0] SEL_APPARENT = 3'h2;
  localparam logic [2:0] SEL_FUND_ACT = 3'h3;
  localparam logic [2:0] SEL_FUND_REACT = 3'h4;
  localparam logic [1:0] T_TOTAL = 2'h0;
  localparam logic [1:0] T_FUND_ACT = 2'h1;
  localparam logic [1:0] T_FUND_REACT = 2'h2;
  localparam logic [1:0] T_APPARENT = 2'h3;
  localparam int CLK_HZ = 100_000_000;
  localparam int LOW_LONG_MS = 80;
  localparam int LOW_LONG_CYC = LOW_LONG_MS * (CLK_HZ / 1000);
  localparam int SHORT_LOW_US = 1;
  localparam int SHORT_LOW_CYC = SHORT_LOW_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic signed [23:0] c;
    logic signed [23:0] b;
    logic signed [23:0] a;
  } phase_pow_s;

  // returns {valid, type index}; reserved codes give no power
  function automatic logic [2:0] sel_to_type(input logic [2:0] sel);
    case (sel)
      SEL_TOTAL: return {1'b1, T_TOTAL};
      SEL_APPARENT: return {1'b1, T_APPARENT};
      SEL_FUND_ACT: return {1'b1, T_FUND_ACT};
      SEL_FUND_REACT: return {1'b1, T_FUND_REACT};
      default: return 3'h0;
    endcase
  endfunction
endpackage

/* rtl/efc_conv.sv */
`timescale 1ns/10ps
module efc_conv #(
  parameter int LOW_LONG = efc_pkg::LOW_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input efc_pkg::phase_pow_s pow_i,
  input wire logic pow_ok_i,
  input wire logic [2:0] incl_i,
  input wire logic [31:0] thresh_i,
  input wire logic [15:0] den_i,
  input wire logic [7:0] cyc_i,
  input wire logic latch_en_i,
  output logic out_n_o,
  output logic fall_o,
  output logic latch_o
);
  import efc_pkg::*;

  logic signed [31:0] acc_q, acc_d;
  logic [15:0] cnt_q, lcnt_q;
  logic [23:0] tmr_q;
  logic [7:0] lc_q;
  logic out_n_q, fall_q, latch_q;

  wire signed [31:0] ext_a = incl_i[0] ? {{8{pow_i.a[23]}}, pow_i.a} : 32'sh0;
  wire signed [31:0] ext_b = incl_i[1] ? {{8{pow_i.b[23]}}, pow_i.b} : 32'sh0;
  wire signed [31:0] ext_c = incl_i[2] ? {{8{pow_i.c[23]}}, pow_i.c} : 32'sh0;
  wire signed [31:0] th = {1'b0, thresh_i[30:0]};
  wire signed [31:0] acc_sum = acc_q + ext_a + ext_b + ext_c;
  wire active = pow_ok_i & (|incl_i);
  wire up = acc_sum >= th;
  wire dn = acc_sum <= -th;
  wire s1_pulse = sample_i & active & (up | dn);

  // residue kept so no energy is lost between first-stage pulses
  always_comb begin
    acc_d = acc_q;
    if (sample_i && active) begin
      if (up) begin
        acc_d = acc_sum - th;
      end else if (dn) begin
        acc_d = acc_sum + th;
      end else begin
        acc_d = acc_sum;
      end
    end
  end

  wire short_mode = den_i <= 16'h0001;
  wire [15:0] den_eff = short_mode ? 16'h0001 : den_i;
  wire [16:0] half_w = ({1'b0, den_eff} + 17'h00001) >> 1;
  wire [15:0] half = half_w[15:0];
  wire wrap = s1_pulse & (({1'b0, cnt_q} + 17'h00001) >= {1'b0, den_eff});
  wire fall = wrap & out_n_q;
  wire low = ~out_n_q;
  // odd divisor: low spans (n+1)/2 input pulses, so duty is (1+1/n)/2
  wire end_cnt = low & ~short_mode & s1_pulse & (({1'b0, lcnt_q} + 17'h00001) >= {1'b0, half});
  wire [23:0] tmr_lim = short_mode ? 24'(SHORT_LOW_CYC - 1) : 24'(LOW_LONG - 1);
  wire end_tmr = low & (tmr_q >= tmr_lim);
  wire [7:0] cyc_eff = (cyc_i == 8'h00) ? 8'h01 : cyc_i;
  wire lc_hit = fall & latch_en_i & (({1'b0, lc_q} + 9'h001) >= {1'b0, cyc_eff});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= 32'sh0;
      cnt_q <= 16'h0000;
    end else begin
      acc_q <= acc_d;
      if (s1_pulse) begin
        cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_n_q <= 1'b1;
      lcnt_q <= 16'h0000;
      tmr_q <= 24'h000000;
    end else begin
      if (fall) begin
        out_n_q <= 1'b0;
      end else if (end_cnt || end_tmr) begin
        out_n_q <= 1'b1;
      end
      lcnt_q <= fall ? 16'h0000 : ((low && s1_pulse) ? lcnt_q + 16'h0001 : lcnt_q);
      tmr_q <= fall ? 24'h000000 : (low ? tmr_q + 24'h000001 : tmr_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lc_q <= 8'h00;
      fall_q <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      fall_q <= fall;
      latch_q <= lc_hit;
      if (fall && latch_en_i) begin
        lc_q <= lc_hit ? 8'h00 : lc_q + 8'h01;
      end
    end
  end

  assign out_n_o = out_n_q;
  assign fall_o = fall_q;
  assign latch_o = latch_q;

  property p_no_terms;
    @(posedge clk_i) disable iff (rst_i)
    (incl_i == 3'h0) |-> !s1_pulse;
  endproperty
  a_no_terms: assert property (p_no_terms) else $error("pulse with no phase included");

  property p_low_cap;
    @(posedge clk_i) disable iff (rst_i)
    !out_n_q |-> (tmr_q < 24'(LOW_LONG));
  endproperty
  a_low_cap: assert property (p_low_cap) else $error("low phase longer than cap");

  property p_wrap_fall;
    @(posedge clk_i) disable iff (rst_i)
    (wrap && out_n_q) |=> (!out_n_q && fall_q);
  endproperty
  a_wrap_fall: assert property (p_wrap_fall) else $error("divisor reached without fall");
endmodule

/* rtl/energy_pulse_output.sv */
`timescale 1ns/10ps
module energy_pulse_output #(
  parameter int LOW_LONG = efc_pkg::LOW_LONG_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic SAMPLE_STB_I,
  input efc_pkg::phase_pow_s [3:0] POWER_I,
  input wire logic [3:0][31:0] THRESHOLD_I,
  input wire logic REG_WR_I,
  input wire logic [4:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  input wire logic HREADY_SEL_I,
  input wire logic HREADY_N_I,
  input wire logic CAPTURE_EN_I,
  input wire logic CAPTURE_PORT_CLOCK_I,
  output logic PULSE_OUT_ONE_N_O,
  output logic PULSE_OUT_TWO_N_O,
  output logic PULSE_OUT_THREE_N_O,
  output logic INTERRUPT_LINE_N_O
);
  import efc_pkg::*;

  logic [8:0] computation_mode_reg_q;
  logic [14:0] pulse_config_reg_q;
  logic [15:0] den_q [NCONV];
  logic [7:0] latch_cycle_count_q;
  logic [2:0] mask_q, status_q, status_d;
  logic irq_n_q;
  logic [2:0] pin_q, pin_d;
  logic [31:0] rdata_q, rdata_d;
  logic signed [31:0] eacc_q [NHOUR];
  logic [31:0] hour_q [NHOUR];
  logic [2:0] conv_n, conv_fall, conv_latch;
  logic [2:0] conv_type [NCONV];
  logic [3:0] latch_type;

  wire wr_computation_mode_reg = REG_WR_I & (REG_ADDR_I == ADDR_COMPUTATION_MODE_REG);
  wire wr_pulse_config_reg = REG_WR_I & (REG_ADDR_I == ADDR_PULSE_CONFIG_REG);
  wire wr_latch_cycle_count = REG_WR_I & (REG_ADDR_I == ADDR_LATCH_CYCLE_COUNT);
  wire wr_mask = REG_WR_I & (REG_ADDR_I == ADDR_MASK);
  wire wr_status = REG_WR_I & (REG_ADDR_I == ADDR_STATUS);
  wire [2:0] status_clr = wr_status ? REG_WDATA_I[IRQ_LSB +: NCONV] : 3'h0;
  wire [2:0] dis = pulse_config_reg_q[DIS_LSB +: NCONV];

  // a falling edge in the same cycle as the clearing write wins
  assign status_d = (status_q & ~status_clr) | conv_fall;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      computation_mode_reg_q <= COMPUTATION_MODE_REG_RST;
      pulse_config_reg_q <= PULSE_CONFIG_REG_RST;
      latch_cycle_count_q <= LATCH_CYCLE_COUNT_RST;
      mask_q <= 3'h0;
    end else begin
      if (wr_computation_mode_reg) begin
        computation_mode_reg_q <= REG_WDATA_I[8:0];
      end
      if (wr_pulse_config_reg) begin
        pulse_config_reg_q <= REG_WDATA_I[14:0];
      end
      if (wr_latch_cycle_count) begin
        latch_cycle_count_q <= REG_WDATA_I[7:0];
      end
      if (wr_mask) begin
        mask_q <= REG_WDATA_I[IRQ_LSB +: NCONV];
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      status_q <= 3'h0;
      irq_n_q <= 1'b1;
    end else begin
      status_q <= status_d;
      irq_n_q <= ~|(status_d & (wr_mask ? REG_WDATA_I[IRQ_LSB +: NCONV] : mask_q));
    end
  end

  genvar i, t, p;
  generate
    for (i = 0; i < NCONV; i++) begin : g_conv
      wire [15:0] den_addr = 16'(ADDR_DEN0) + 16'(i);
      assign conv_type[i] = sel_to_type(pulse_config_reg_q[SEL_W*i +: SEL_W]);

      always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
          den_q[i] <= DEN_RST;
        end else if (REG_WR_I && ({11'h000, REG_ADDR_I} == den_addr)) begin
          den_q[i] <= REG_WDATA_I[15:0];
        end
      end

      efc_conv #(
        .LOW_LONG(LOW_LONG)
      ) u_conv (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .sample_i(SAMPLE_STB_I),
        .pow_i(POWER_I[conv_type[i][1:0]]),
        .pow_ok_i(conv_type[i][2]),
        .incl_i(computation_mode_reg_q[TERM_W*i +: TERM_W]),
        .thresh_i(THRESHOLD_I[conv_type[i][1:0]]),
        .den_i(den_q[i]),
        .cyc_i(latch_cycle_count_q),
        .latch_en_i(pulse_config_reg_q[LATCH_LSB + i]),
        .out_n_o(conv_n[i]),
        .fall_o(conv_fall[i]),
        .latch_o(conv_latch[i])
      );
    end

    for (t = 0; t < NTYPE; t++) begin : g_type
      // several converters may share a type; any of them latches that set
      assign latch_type[t] = |{conv_latch[0] & conv_type[0][2] & (conv_type[0][1:0] == 2'(t)),
                               conv_latch[1] & conv_type[1][2] & (conv_type[1][1:0] == 2'(t)),
                               conv_latch[2] & conv_type[2][2] & (conv_type[2][1:0] == 2'(t))};
      for (p = 0; p < 3; p++) begin : g_phase
        wire signed [23:0] pw = POWER_I[t][24*p +: 24];
        always_ff @(posedge REF_CLK_I) begin
          if (RST_I) begin
            eacc_q[3*t+p] <= 32'sh0;
            hour_q[3*t+p] <= 32'h0;
          end else if (latch_type[t]) begin
            hour_q[3*t+p] <= eacc_q[3*t+p];
            eacc_q[3*t+p] <= 32'sh0;
          end else if (SAMPLE_STB_I) begin
            eacc_q[3*t+p] <= eacc_q[3*t+p] + {{8{pw[23]}}, pw};
          end
        end
      end
    end
  endgenerate

  // pin mux: the pin function takes priority over the converter
  assign pin_d[0] = dis[0] | conv_n[0];
  assign pin_d[1] = HREADY_SEL_I ? HREADY_N_I : (dis[1] | conv_n[1]);
  assign pin_d[2] = CAPTURE_EN_I ? CAPTURE_PORT_CLOCK_I : (dis[2] | conv_n[2]);

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      pin_q <= 3'h7;
    end else begin
      pin_q <= pin_d;
    end
  end

  wire [4:0] hidx = REG_ADDR_I - ADDR_HOUR0;
  wire hour_hit = (REG_ADDR_I >= ADDR_HOUR0) && (hidx < 5'(NHOUR));
  wire [1:0] didx = 2'(REG_ADDR_I - ADDR_DEN0);
  wire den_hit = (REG_ADDR_I >= ADDR_DEN0) && (REG_ADDR_I < ADDR_LATCH_CYCLE_COUNT);

  always_comb begin
    rdata_d = 32'h0;
    if (REG_ADDR_I == ADDR_COMPUTATION_MODE_REG) begin
      rdata_d = {23'h0, computation_mode_reg_q};
    end else if (REG_ADDR_I == ADDR_PULSE_CONFIG_REG) begin
      rdata_d = {17'h0, pulse_config_reg_q};
    end else if (den_hit) begin
      rdata_d = {16'h0, den_q[didx]};
    end else if (REG_ADDR_I == ADDR_LATCH_CYCLE_COUNT) begin
      rdata_d = {24'h0, latch_cycle_count_q};
    end else if (REG_ADDR_I == ADDR_MASK) begin
      rdata_d = {15'h0, mask_q, 14'h0};
    end else if (REG_ADDR_I == ADDR_STATUS) begin
      rdata_d = {15'h0, status_q, 14'h0};
    end else if (hour_hit) begin
      rdata_d = hour_q[hidx[3:0]];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA_O = rdata_q;
  assign PULSE_OUT_ONE_N_O = pin_q[0];
  assign PULSE_OUT_TWO_N_O = pin_q[1];
  assign PULSE_OUT_THREE_N_O = pin_q[2];
  assign INTERRUPT_LINE_N_O = irq_n_q;

  property p_irq_level;
    @(posedge REF_CLK_I) disable iff (RST_I)
    INTERRUPT_LINE_N_O == ~|(status_q & mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt line disagrees");

  property p_fall_sets;
    @(posedge REF_CLK_I) disable iff (RST_I)
    conv_fall[0] |=> status_q[0];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_w1c;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (wr_status && REG_WDATA_I[IRQ_LSB] && !conv_fall[0]) |=> !status_q[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");

  property p_dis_high;
    @(posedge REF_CLK_I) disable iff (RST_I)
    dis[0] |=> PULSE_OUT_ONE_N_O;
  endproperty
  a_dis_high: assert property (p_dis_high) else $error("disabled pin went low");

  property p_capture;
    @(posedge REF_CLK_I) disable iff (RST_I)
    CAPTURE_EN_I |=> (PULSE_OUT_THREE_N_O == $past(CAPTURE_PORT_CLOCK_I));
  endproperty
  a_capture: assert property (p_capture) else $error("pin three not capture clock");

  property p_hready;
    @(posedge REF_CLK_I) disable iff (RST_I)
    HREADY_SEL_I |=> (PULSE_OUT_TWO_N_O == $past(HREADY_N_I));
  endproperty
  a_hready: assert property (p_hready) else $error("pin two not harmonic ready");

  property p_latch_copy;
    @(posedge REF_CLK_I) disable iff (RST_I)
    latch_type[0] |=> (hour_q[0] == $past(eacc_q[0])) && (eacc_q[0] == 32'sh0);
  endproperty
  a_latch_copy: assert property (p_latch_copy) else $error("latch copy or clear wrong");
endmodule

/* sim/pulse_meter.sv */
`timescale 1ns/10ps
module pulse_meter (
  input wire logic clk_i,
  input wire logic pin_n_i,
  input wire logic clr_i,
  output int falls_o,
  output int low_o,
  output int period_o
);
  // far-side optical counter: counts falls, times each low phase and each period
  // it only listens; it never drives the pin, so it cannot mask a stuck output
  logic last_q = 1'b1;
  int low_cnt = 0;
  int per_cnt = 0;
  initial begin
    falls_o = 0;
    low_o = 0;
    period_o = 0;
  end
  always @(posedge clk_i) begin
    last_q <= pin_n_i;
    low_cnt <= pin_n_i ? 0 : low_cnt + 1;
    per_cnt <= (last_q && !pin_n_i) ? 1 : per_cnt + 1;
    if (!last_q && pin_n_i) low_o <= low_cnt;
    if (last_q && !pin_n_i) period_o <= per_cnt;
    if (clr_i) falls_o <= 0;
    else if (last_q && !pin_n_i) falls_o <= falls_o + 1;
  end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import efc_pkg::*;
  logic REF_CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic SAMPLE_STB_I = 1'b0;
  phase_pow_s [3:0] POWER_I;
  logic [3:0][31:0] THRESHOLD_I;
  logic REG_WR_I = 1'b0;
  logic [4:0] REG_ADDR_I = 5'h00;
  logic [31:0] REG_WDATA_I = 32'h00000000;
  logic [31:0] REG_RDATA_O;
  logic HREADY_SEL_I = 1'b0;
  logic HREADY_N_I = 1'b1;
  logic CAPTURE_EN_I = 1'b0;
  logic CAPTURE_PORT_CLOCK_I = 1'b1;
  logic PULSE_OUT_ONE_N_O, PULSE_OUT_TWO_N_O, PULSE_OUT_THREE_N_O, INTERRUPT_LINE_N_O;
  logic clr = 1'b0;
  int f1, f2, f3, l1, l2, l3, p1, p2, p3;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] ha, hb, v;
  logic [4:0] ra [7] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h1f};
  logic [31:0] rv [7] = '{32'h1ff, 32'h0ea0, 32'h0, 32'h01, 32'h0, 32'h0, 32'h0};

  // long low phase shortened to 200 cycles so the over-limit case fits the run
  energy_pulse_output #(.LOW_LONG(200)) u_energy_pulse_output (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .SAMPLE_STB_I(SAMPLE_STB_I),
    .POWER_I(POWER_I), .THRESHOLD_I(THRESHOLD_I), .REG_WR_I(REG_WR_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .HREADY_SEL_I(HREADY_SEL_I), .HREADY_N_I(HREADY_N_I), .CAPTURE_EN_I(CAPTURE_EN_I),
    .CAPTURE_PORT_CLOCK_I(CAPTURE_PORT_CLOCK_I), .PULSE_OUT_ONE_N_O(PULSE_OUT_ONE_N_O),
    .PULSE_OUT_TWO_N_O(PULSE_OUT_TWO_N_O), .PULSE_OUT_THREE_N_O(PULSE_OUT_THREE_N_O),
    .INTERRUPT_LINE_N_O(INTERRUPT_LINE_N_O));
  pulse_meter u_pulse_meter_one (.clk_i(REF_CLK_I), .pin_n_i(PULSE_OUT_ONE_N_O),
    .clr_i(clr), .falls_o(f1), .low_o(l1), .period_o(p1));
  pulse_meter u_pulse_meter_two (.clk_i(REF_CLK_I), .pin_n_i(PULSE_OUT_TWO_N_O),
    .clr_i(clr), .falls_o(f2), .low_o(l2), .period_o(p2));
  pulse_meter u_pulse_meter_three (.clk_i(REF_CLK_I), .pin_n_i(PULSE_OUT_THREE_N_O),
    .clr_i(clr), .falls_o(f3), .low_o(l3), .period_o(p3));

  initial begin
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(negedge REF_CLK_I);
    REG_WR_I = 1'b1;
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    @(negedge REF_CLK_I);
    REG_WR_I = 1'b0;
  endtask

  // read data is registered: address goes out, the value is there one edge later
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(negedge REF_CLK_I);
    REG_ADDR_I = a;
    @(negedge REF_CLK_I);
    d = REG_RDATA_O;
  endtask

  // one power sample every 20 cycles, so periods and lows come in multiples of 20
  task automatic run(input int n);
    repeat (n) begin
      @(negedge REF_CLK_I);
      SAMPLE_STB_I = 1'b1;
      @(negedge REF_CLK_I);
      SAMPLE_STB_I = 1'b0;
      repeat (18) @(negedge REF_CLK_I);
    end
  endtask

  task automatic clr_m();
    @(negedge REF_CLK_I);
    clr = 1'b1;
    @(negedge REF_CLK_I);
    clr = 1'b0;
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #300_000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    for (int i = 0; i < 4; i++) begin
      POWER_I[i].a = 24'sh000001;
      POWER_I[i].b = 24'sh000002;
      POWER_I[i].c = 24'sh000000;
      THRESHOLD_I[i] = 32'h00000001;
    end
    repeat (8) @(negedge REF_CLK_I);
    RST_I = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], v);
      chk("reset_value", v, rv[i]);
    end
    chk("pins_idle", {PULSE_OUT_ONE_N_O, PULSE_OUT_TWO_N_O, PULSE_OUT_THREE_N_O}, 3'h7);
    wr(ADDR_COMPUTATION_MODE_REG, 32'h049);
    wr(ADDR_DEN0, 32'h4);
    wr(5'h03, 32'h3);
    wr(5'h04, 32'h0);
    wr(ADDR_MASK, 32'h1c000);
    wr(ADDR_PULSE_CONFIG_REG, 32'h10a0);
    run(16);
    chk("low_even", l1, 40);
    chk("period_even", p1, 80);
    chk("low_odd", l2, 40);
    chk("period_odd", p2, 60);
    chk("low_zero_div", l3, 100);
    rd(ADDR_STATUS, v);
    chk("status", v, 32'h1c000);
    chk("irq", INTERRUPT_LINE_N_O, 1'b0);
    rd(ADDR_HOUR0, ha);
    rd(5'h09, hb);
    chk("hour_b", hb, ha << 1);
    chk("hour_a_set", ha != 0, 1'b1);
    rd(5'h0e, v);
    chk("hour_unlatched", v, 32'h0);
    wr(ADDR_STATUS, 32'h1c000);
    rd(ADDR_STATUS, v);
    chk("status_clr", v, 32'h0);
    chk("irq_clr", INTERRUPT_LINE_N_O, 1'b1);
    wr(ADDR_PULSE_CONFIG_REG, 32'h12a0);
    clr_m();
    run(8);
    chk("disabled_falls", f1, 0);
    rd(ADDR_STATUS, v);
    chk("status_disabled", v & 32'h4000, 32'h4000);
    wr(ADDR_PULSE_CONFIG_REG, 32'h10a0);
    wr(ADDR_DEN0, 32'd40);
    clr_m();
    run(90);
    chk("low_long", l1, 200);
    wr(ADDR_DEN0, 32'h4);
    // written between sample bursts, so no converter edge can coincide with it
    wr(ADDR_LATCH_CYCLE_COUNT, 32'h2);
    run(24);
    // latch every second fall: two periods of four samples each land in the hour register
    rd(ADDR_HOUR0, ha);
    chk("hour_two_falls", ha, 32'd8);
    for (int code = 0; code < 8; code++) begin
      wr(ADDR_PULSE_CONFIG_REG, 32'h00a0 | code);
      clr_m();
      run(12);
      chk("type_code", f1 > 0, code == 0 || code == 2 || code == 3 || code == 4);
    end
    wr(ADDR_PULSE_CONFIG_REG, 32'h00a0);
    wr(ADDR_COMPUTATION_MODE_REG, 32'h044);
    clr_m();
    run(12);
    chk("phase_c_only", f1, 0);
    chk("no_phase", f2, 0);
    chk("field_three", f3 > 0, 1'b1);
    wr(ADDR_COMPUTATION_MODE_REG, 32'h049);
    HREADY_SEL_I = 1'b1;
    HREADY_N_I = 1'b0;
    CAPTURE_EN_I = 1'b1;
    CAPTURE_PORT_CLOCK_I = 1'b0;
    repeat (2) @(negedge REF_CLK_I);
    chk("hready_pin", PULSE_OUT_TWO_N_O, 1'b0);
    chk("capture_pin", PULSE_OUT_THREE_N_O, 1'b0);
    HREADY_N_I = 1'b1;
    CAPTURE_PORT_CLOCK_I = 1'b1;
    clr_m();
    run(12);
    chk("hready_blocks", f2, 0);
    chk("capture_blocks", f3, 0);
    chk("pin_one_free", f1 > 0, 1'b1);
    report_and_stop();
  end
endmodule
